// File: hdl/flash_seq_params.svh
// constants for the flash self-program sequencer
`ifndef FLASH_SEQ_PARAMS_SVH
`define FLASH_SEQ_PARAMS_SVH
`define CTRL_ENABLE_BIT      0
`define CTRL_ERASE_BIT       1
`define CTRL_WRITE_BIT       2
`define CTRL_LOCKFUSE_BIT    3
`define CTRL_BUFCLR_BIT      4
`define CTRL_RESET_VALUE     8'h00
`define CODE_ERASE           8'h03
`define CODE_LOAD            8'h01
`define CODE_WRITE           8'h05
`define CODE_LOCKFUSE        8'h09
`define CODE_BUFCLR          8'h11
`define STORE_WINDOW_CYCLES  3'd4
`define LOAD_WINDOW_CYCLES   3'd3
`define PTR_LOCK             16'h0001
`define PTR_FUSE_LOW         16'h0000
`define PTR_FUSE_EXT         16'h0002
`define PTR_FUSE_HIGH        16'h0003
`define PROG_TIME_US         3200
`define CLK_MHZ              25
`define PROG_CYCLES          (`PROG_TIME_US * `CLK_MHZ)
`define PAGE_MSB             12
`define PAGE_LSB             6
`define WORD_MSB             5
`define WORD_LSB             1
`endif

// File: hdl/flash_seq_pkg.sv
// types for the flash self-program sequencer
package flash_seq_pkg;
  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_ARMED = 4'b0010,
    ST_BUSY  = 4'b0100,
    ST_DONE  = 4'b1000
  } seq_state_e;
  typedef logic [7:0]  byte_t;
  typedef logic [15:0] word_t;
endpackage

// File: hdl/prog_timer.sv
// programming timer for erase and write
`timescale 1ns/100ps
`default_nettype none
module prog_timer #(
  parameter int CYCLES = 80000
) (
  input  wire logic clk_in,
  input  wire logic resetn_in,
  input  wire logic start_in,
  output logic      done_out
);
  logic [31:0] count_reg;
  logic [31:0] count_next;
  logic        done_reg;
  logic        done_next;
  // down counter, one-cycle done at zero
  always_comb begin
    count_next = count_reg;
    done_next  = 1'b0;
    if (start_in) begin
      count_next = 32'(CYCLES);
    end else if (count_reg != 32'h0) begin
      count_next = count_reg - 32'h1;
      done_next  = (count_reg == 32'h1);
    end
  end
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      count_reg <= 32'h0;
      done_reg  <= 1'b0;
    end else begin
      count_reg <= count_next;
      done_reg  <= done_next;
    end
  end
  assign done_out = done_reg;
endmodule // prog_timer
`default_nettype wire

// File: hdl/page_buffer.sv
// temporary page buffer, one word per slot
`timescale 1ns/100ps
`default_nettype none
module page_buffer #(
  parameter int WORDS = 32,
  parameter int AW    = 5
) (
  input  wire logic          clk_in,
  input  wire logic          resetn_in,
  input  wire logic          clear_in,
  input  wire logic          load_in,
  input  wire logic [AW-1:0] slot_in,
  input  wire logic [15:0]   data_in,
  input  wire logic [AW-1:0] rd_slot_in,
  output logic      [15:0]   rd_data_out
);
  logic [15:0] mem_reg  [WORDS];
  logic [15:0] mem_next [WORDS];
  // erased buffer holds all ones
  always_comb begin
    for (int i = 0; i < WORDS; i++) begin
      mem_next[i] = mem_reg[i];
    end
    if (clear_in) begin
      for (int i = 0; i < WORDS; i++) begin
        mem_next[i] = 16'hffff;
      end
    end else if (load_in) begin
      mem_next[slot_in] = data_in;
    end
  end
  always_ff @(posedge clk_in) begin
    for (int i = 0; i < WORDS; i++) begin
      if (!resetn_in) begin
        mem_reg[i] <= 16'hffff;
      end else begin
        mem_reg[i] <= mem_next[i];
      end
    end
  end
  assign rd_data_out = mem_reg[rd_slot_in];
endmodule // page_buffer
`default_nettype wire

// File: hdl/flash_self_program_sequencer.sv
// flash self-program sequencer top
`timescale 1ns/100ps
`default_nettype none
`include "flash_seq_params.svh"

// Overview of operation
// - erase code then store within four cycles
// - erase page from pointer bits 12..6
// - core stalled during erase and write
// - enable-only code then store loads word
// - buffer slot from pointer bits 5..1
// - buffer cleared: after write, clear bit, reset
// - eeprom write during loading discards buffer
// - write code then store programs page
// - loads any order, before or after erase
// - eeprom busy blocks programming and fuse reads
// - pointer one reads lock bits
// - lock/fuse bits self-clear on done/timeout
// - pointer zero reads fuse low byte
// - pointer three reads fuse high byte
// - pointer two reads fuse extended byte
// - programmed reads zero, unprogrammed reads one
// - plain loads read flash bytes, bit0 selects
// - write select clears on done or timeout
// - enable alone means buffer word load
module flash_self_program_sequencer #(
  parameter int PROG_CYCLES = `PROG_CYCLES,
  parameter int WORDS       = 32
) (
  input  wire logic               clk_in,
  input  wire logic               resetn_in,
  input  wire logic [7:0]         addr_in,
  input  wire logic [7:0]         wdata_in,
  input  wire logic               wr_in,
  input  wire logic               rd_in,
  output logic      [7:0]         rdata_out,
  input  wire logic               store_prog_in,
  input  wire logic               load_prog_in,
  input  wire flash_seq_pkg::word_t pointer_in,
  input  wire flash_seq_pkg::word_t data_register_pair_in,
  input  wire logic               eeprom_write_busy_in,
  input  wire flash_seq_pkg::byte_t lock_bits_in,
  input  wire flash_seq_pkg::byte_t fuse_low_byte_in,
  input  wire flash_seq_pkg::byte_t fuse_high_byte_in,
  input  wire flash_seq_pkg::byte_t fuse_extended_byte_in,
  input  wire flash_seq_pkg::word_t flash_word_in,
  output logic      [15:0]        flash_addr_out,
  output logic      [7:0]         load_data_out,
  output logic                    load_valid_out,
  output logic                    core_stall_out,
  output logic                    erase_start_out,
  output logic                    write_start_out,
  output logic      [6:0]         prog_page_out,
  output logic      [15:0]        prog_word_out,
  output logic      [4:0]         prog_slot_out
);
  import flash_seq_pkg::*;

  localparam logic [7:0] CTRL_ADDR = 8'h00;

  seq_state_e  state_reg, state_next;
  logic [7:0]  ctrl_reg, ctrl_next;
  logic [2:0]  win_reg, win_next;
  logic        stall_reg, stall_next;
  logic [6:0]  page_reg, page_next;
  logic        is_write_reg, is_write_next;
  logic        ers_pls_reg, ers_pls_next;
  logic        wrt_pls_reg, wrt_pls_next;
  logic [7:0]  rdata_reg, rdata_next;
  logic [7:0]  ld_data_reg, ld_data_next;
  logic        ld_valid_reg, ld_valid_next;
  logic [15:0] faddr_reg, faddr_next;
  logic [4:0]  slot_reg, slot_next;
  logic [15:0] pword_reg, pword_next;
  logic        buf_clear;
  logic        buf_load;
  logic        timer_start;
  logic        timer_done;
  logic        loading_reg, loading_next;
  logic [15:0] buf_rd_data;

  // selects lock or fuse byte by pointer
  function automatic logic [7:0] lock_fuse_sel(input logic [15:0] p, input logic [7:0] lb,
                                               input logic [7:0] fl, input logic [7:0] fh,
                                               input logic [7:0] fe);
    logic [7:0] r;
    r = fl;
    unique case (p[1:0])
      2'b00: r = fl;
      2'b01: r = lb;
      2'b10: r = fe;
      2'b11: r = fh;
    endcase
    return r;
  endfunction

  // page number field of the pointer
  function automatic logic [6:0] page_of(input logic [15:0] p);
    return p[`PAGE_MSB:`PAGE_LSB];
  endfunction

  // word slot field of the pointer
  function automatic logic [4:0] slot_of(input logic [15:0] p);
    return p[`WORD_MSB:`WORD_LSB];
  endfunction

  wire ctrl_wr  = wr_in && (addr_in == CTRL_ADDR);
  wire code_ok  = !eeprom_write_busy_in;
  wire en_bit   = ctrl_reg[`CTRL_ENABLE_BIT];
  wire lf_armed = en_bit && ctrl_reg[`CTRL_LOCKFUSE_BIT];
  wire act_bits = |ctrl_reg[`CTRL_BUFCLR_BIT:`CTRL_ERASE_BIT];

  // control register, arming window and action sequencing
  always_comb begin
    state_next    = state_reg;
    ctrl_next     = ctrl_reg;
    win_next      = win_reg;
    stall_next    = stall_reg;
    page_next     = page_reg;
    is_write_next = is_write_reg;
    ers_pls_next  = 1'b0;
    wrt_pls_next  = 1'b0;
    buf_clear     = 1'b0;
    buf_load      = 1'b0;
    timer_start   = 1'b0;
    slot_next     = slot_reg;
    pword_next    = buf_rd_data; // word held in the slot last loaded
    loading_next  = loading_reg;
    unique case (state_reg)
      ST_IDLE: begin
        if (ctrl_wr && code_ok && wdata_in[`CTRL_ENABLE_BIT]) begin
          ctrl_next  = wdata_in & 8'h1f;
          win_next   = 3'd0;
          state_next = ST_ARMED;
          if (wdata_in == `CODE_BUFCLR) begin
            buf_clear    = 1'b1;
            loading_next = 1'b0;
          end
        end
      end
      ST_ARMED: begin
        win_next = win_reg + 3'd1;
        if (lf_armed && load_prog_in && code_ok) begin
          ctrl_next  = `CTRL_RESET_VALUE;
          state_next = ST_IDLE;
        end else if (store_prog_in && !lf_armed && code_ok) begin
          ctrl_next  = `CTRL_RESET_VALUE;
          state_next = ST_IDLE;
          if (ctrl_reg == `CODE_ERASE) begin
            page_next     = page_of(pointer_in);
            is_write_next = 1'b0;
            ers_pls_next  = 1'b1;
            ctrl_next     = ctrl_reg;
            stall_next    = 1'b1;
            timer_start   = 1'b1;
            state_next    = ST_BUSY;
          end else if (ctrl_reg == `CODE_WRITE) begin
            page_next     = page_of(pointer_in);
            is_write_next = 1'b1;
            wrt_pls_next  = 1'b1;
            ctrl_next     = ctrl_reg;
            stall_next    = 1'b1;
            timer_start   = 1'b1;
            state_next    = ST_BUSY;
          end else if (!act_bits) begin
            // any slot order accepted
            buf_load     = 1'b1;
            loading_next = 1'b1;
            slot_next    = slot_of(pointer_in);
          end
        end else if ((lf_armed && win_reg >= `LOAD_WINDOW_CYCLES - 3'd1) ||
                     (win_reg >= `STORE_WINDOW_CYCLES - 3'd1)) begin
          ctrl_next  = `CTRL_RESET_VALUE;
          state_next = ST_IDLE;
        end
      end
      ST_BUSY: begin
        if (timer_done) begin
          state_next = ST_DONE;
        end
      end
      ST_DONE: begin
        stall_next = 1'b0;
        ctrl_next  = `CTRL_RESET_VALUE;
        state_next = ST_IDLE;
        if (is_write_reg) begin
          buf_clear    = 1'b1;
          loading_next = 1'b0;
        end
      end
    endcase
    if (eeprom_write_busy_in && loading_reg) begin
      buf_clear    = 1'b1;
      loading_next = 1'b0;
    end
  end

  // read path: register read, lock/fuse and flash byte loads
  always_comb begin
    rdata_next    = 8'h00;
    ld_valid_next = 1'b0;
    ld_data_next  = ld_data_reg;
    faddr_next    = faddr_reg;
    if (rd_in && addr_in == CTRL_ADDR) begin
      rdata_next = ctrl_reg;
    end
    if (load_prog_in) begin
      if (state_reg == ST_ARMED && lf_armed) begin
        if (code_ok) begin
          ld_valid_next = 1'b1;
          ld_data_next  = lock_fuse_sel(pointer_in, lock_bits_in, fuse_low_byte_in,
                                        fuse_high_byte_in, fuse_extended_byte_in);
        end
      end else begin
        faddr_next    = {1'b0, pointer_in[15:1]};
        ld_valid_next = 1'b1;
        ld_data_next  = pointer_in[0] ? flash_word_in[15:8] : flash_word_in[7:0];
      end
    end
  end

  // sequencer and output registers
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      state_reg    <= ST_IDLE;
      ctrl_reg     <= `CTRL_RESET_VALUE;
      win_reg      <= 3'd0;
      stall_reg    <= 1'b0;
      page_reg     <= 7'h00;
      is_write_reg <= 1'b0;
      ers_pls_reg  <= 1'b0;
      wrt_pls_reg  <= 1'b0;
      rdata_reg    <= 8'h00;
      ld_data_reg  <= 8'h00;
      ld_valid_reg <= 1'b0;
      faddr_reg    <= 16'h0000;
      slot_reg     <= 5'h00;
      pword_reg    <= 16'h0000;
      loading_reg  <= 1'b0;
    end else begin
      state_reg    <= state_next;
      ctrl_reg     <= ctrl_next;
      win_reg      <= win_next;
      stall_reg    <= stall_next;
      page_reg     <= page_next;
      is_write_reg <= is_write_next;
      ers_pls_reg  <= ers_pls_next;
      wrt_pls_reg  <= wrt_pls_next;
      rdata_reg    <= rdata_next;
      ld_data_reg  <= ld_data_next;
      ld_valid_reg <= ld_valid_next;
      faddr_reg    <= faddr_next;
      slot_reg     <= slot_next;
      pword_reg    <= pword_next;
      loading_reg  <= loading_next;
    end
  end

  // erase and write duration
  prog_timer #(
    .CYCLES    (PROG_CYCLES)
  ) u_timer (
    .clk_in    (clk_in),
    .resetn_in (resetn_in),
    .start_in  (timer_start),
    .done_out  (timer_done)
  );

  // temporary page buffer, cleared by reset too
  page_buffer #(
    .WORDS       (WORDS),
    .AW          (5)
  ) u_buf (
    .clk_in      (clk_in),
    .resetn_in   (resetn_in),
    .clear_in    (buf_clear),
    .load_in     (buf_load),
    .slot_in     (slot_of(pointer_in)),
    .data_in     (data_register_pair_in),
    .rd_slot_in  (slot_reg),
    .rd_data_out (buf_rd_data)
  );

  // outputs straight from their registers
  assign rdata_out       = rdata_reg;
  assign load_data_out   = ld_data_reg;
  assign load_valid_out  = ld_valid_reg;
  assign core_stall_out  = stall_reg;
  assign erase_start_out = ers_pls_reg;
  assign write_start_out = wrt_pls_reg;
  assign prog_page_out   = page_reg;
  assign flash_addr_out  = faddr_reg;
  assign prog_slot_out   = slot_reg;
  assign prog_word_out   = pword_reg;
endmodule // flash_self_program_sequencer
`default_nettype wire

// File: bench/flash_seq_assertions.sv
// assertion checker for the flash self-program sequencer ports
`timescale 1ns/100ps
`default_nettype none
`include "flash_seq_params.svh"
module flash_seq_checker #(
  parameter int PROG_CYCLES = 20
) (
  input wire logic                 clk_in,
  input wire logic                 resetn_in,
  input wire logic [7:0]           addr_in,
  input wire logic [7:0]           wdata_in,
  input wire logic                 wr_in,
  input wire logic                 store_prog_in,
  input wire flash_seq_pkg::word_t pointer_in,
  input wire logic                 eeprom_write_busy_in,
  input wire logic                 load_valid_out,
  input wire logic                 core_stall_out,
  input wire logic                 erase_start_out,
  input wire logic                 write_start_out,
  input wire logic [6:0]           prog_page_out
);
  import flash_seq_pkg::*;
  logic [15:0] stall_cnt_reg;
  logic [15:0] stall_cnt_next;
  // length of the current stall
  always_comb stall_cnt_next = core_stall_out ? stall_cnt_reg + 16'h0001 : 16'h0000;
  always_ff @(posedge clk_in) stall_cnt_reg <= resetn_in ? stall_cnt_next : 16'h0000;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  sequence s_wr(logic [7:0] code);
    wr_in && addr_in == 8'h00 && wdata_in == code && !eeprom_write_busy_in;
  endsequence
  property p_erase_go;
    s_wr(`CODE_ERASE) ##1 store_prog_in |=> erase_start_out && core_stall_out;
  endproperty
  a_erase_go: assert property (p_erase_go) else $error("erase did not start");
  property p_write_go;
    s_wr(`CODE_WRITE) ##1 store_prog_in |=> write_start_out && core_stall_out;
  endproperty
  a_write_go: assert property (p_write_go) else $error("write did not start");
  property p_late;
    s_wr(`CODE_ERASE) ##1 !store_prog_in [*4] ##1 store_prog_in |=> !erase_start_out;
  endproperty
  a_late: assert property (p_late) else $error("late store accepted");
  property p_page;
    erase_start_out || write_start_out |-> prog_page_out == $past(pointer_in[12:6]);
  endproperty
  a_page: assert property (p_page) else $error("wrong page");
  property p_stall_start;
    $rose(core_stall_out) |-> erase_start_out || write_start_out;
  endproperty
  a_stall_start: assert property (p_stall_start) else $error("stall without op");
  property p_stall_hold;
    $rose(core_stall_out) |-> core_stall_out [*8];
  endproperty
  a_stall_hold: assert property (p_stall_hold) else $error("stall too short");
  property p_stall_max;
    core_stall_out |-> stall_cnt_reg < PROG_CYCLES + 3;
  endproperty
  a_stall_max: assert property (p_stall_max) else $error("stall too long");
  property p_stall_len;
    $fell(core_stall_out) && $past(resetn_in) |-> stall_cnt_reg == 16'(PROG_CYCLES + 2);
  endproperty
  a_stall_len: assert property (p_stall_len) else $error("stall length wrong");
  property p_busy_block;
    eeprom_write_busy_in && store_prog_in |=> !erase_start_out && !write_start_out;
  endproperty
  a_busy_block: assert property (p_busy_block) else $error("op while eeprom busy");
  property p_valid_pulse;
    load_valid_out |=> !load_valid_out;
  endproperty
  a_valid_pulse: assert property (p_valid_pulse) else $error("load result held");
endmodule // flash_seq_checker
bind flash_self_program_sequencer flash_seq_checker #(.PROG_CYCLES(PROG_CYCLES)) chk_u (.clk_in, .resetn_in,
  .addr_in, .wdata_in, .wr_in, .store_prog_in, .pointer_in, .eeprom_write_busy_in, .load_valid_out,
  .core_stall_out, .erase_start_out, .write_start_out, .prog_page_out);
`default_nettype wire

// File: bench/core_model.sv
// core model issuing store and load program instructions
`timescale 1ns/100ps
`default_nettype none
module core_model (
  input  wire logic       clk_in,
  input  wire logic       req_in,
  input  wire logic       is_load_in,
  input  wire logic [2:0] delay_in,
  input  wire logic       stall_in,
  output logic            store_prog_out,
  output logic            load_prog_out
);
  // one instruction per request, the asked number of cycles after it
  initial begin
    store_prog_out = 1'b0;
    load_prog_out  = 1'b0;
    forever begin
      @(posedge clk_in);
      if (req_in === 1'b1) begin
        repeat (int'(delay_in) - 1) @(posedge clk_in);
        while (stall_in === 1'b1) @(posedge clk_in);
        if (is_load_in) load_prog_out <= 1'b1;
        else store_prog_out <= 1'b1;
        @(posedge clk_in);
        store_prog_out <= 1'b0;
        load_prog_out  <= 1'b0;
      end
    end
  end
endmodule // core_model
`default_nettype wire

// File: bench/flash_self_program_sequencer_tb_top.sv
// testbench for the flash self-program sequencer
`timescale 1ns/100ps
`default_nettype none
`include "flash_seq_params.svh"
module flash_self_program_sequencer_tb_top;
  import flash_seq_pkg::*;
  localparam int PC = 20;
  typedef struct {logic [7:0] code; word_t p; logic [7:0] exp;} row_s;
  logic       clk_in, resetn_in, wr_in, rd_in, busy, req, is_load, store_prog_in, load_prog_in;
  logic       load_valid_out, core_stall_out, erase_start_out, write_start_out;
  logic [7:0] addr_in, wdata_in, rdata_out, load_data_out;
  logic [2:0] dly;
  logic [6:0] prog_page_out;
  logic [4:0] prog_slot_out;
  word_t      ptr, drp, flash_addr_out, prog_word_out;
  int         miscompares, n_tests;
  logic [7:0] late [2] = '{`CODE_ERASE, `CODE_WRITE};
  row_s       rows [6] = '{'{`CODE_LOCKFUSE, 16'h0001, 8'hc3}, '{`CODE_LOCKFUSE, 16'h0000, 8'h62},
                           '{`CODE_LOCKFUSE, 16'h0003, 8'hdf}, '{`CODE_LOCKFUSE, 16'h0002, 8'hf9},
                           '{8'h00, 16'h1234, 8'h5a}, '{8'h00, 16'h1235, 8'ha5}};
  flash_self_program_sequencer #(.PROG_CYCLES(PC)) dut_u (.clk_in, .resetn_in, .addr_in, .wdata_in, .wr_in,
    .rd_in, .rdata_out, .store_prog_in, .load_prog_in, .pointer_in(ptr), .data_register_pair_in(drp),
    .eeprom_write_busy_in(busy), .lock_bits_in(8'hc3), .fuse_low_byte_in(8'h62), .fuse_high_byte_in(8'hdf),
    .fuse_extended_byte_in(8'hf9), .flash_word_in(16'ha55a), .flash_addr_out, .load_data_out,
    .load_valid_out, .core_stall_out, .erase_start_out, .write_start_out, .prog_page_out, .prog_word_out,
    .prog_slot_out);
  core_model core_u (.clk_in, .req_in(req), .is_load_in(is_load), .delay_in(dly), .stall_in(core_stall_out),
    .store_prog_out(store_prog_in), .load_prog_out(load_prog_in));
  // clock
  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  // control write, then the core issues its instruction
  task automatic wr_ctrl(input logic [7:0] c, input word_t p, input word_t d, input logic ld, input logic [2:0] n);
    @(posedge clk_in);
    wr_in    <= 1'b1;
    addr_in  <= 8'h00;
    wdata_in <= c;
    ptr      <= p;
    drp      <= d;
    req      <= 1'b1;
    is_load  <= ld;
    dly      <= n;
    @(posedge clk_in);
    wr_in <= 1'b0;
    req   <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp, input string m);
    @(posedge clk_in);
    rd_in   <= 1'b1;
    addr_in <= a;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 chk({8'h00, rdata_out}, {8'h00, exp}, m);
  endtask
  // bounded wait: 0 load result, 1 erase start, 2 write start, 3 stall low
  task automatic wait_out(input int sel, input int lim, input bit want);
    bit hit;
    hit = 1'b0;
    repeat (lim) begin
      @(posedge clk_in);
      #1;
      case (sel)
        0: hit = load_valid_out === 1'b1;
        1: hit = erase_start_out === 1'b1;
        2: hit = write_start_out === 1'b1;
        default: hit = core_stall_out === 1'b0;
      endcase
      if (hit) break;
    end
    chk({15'h0, hit}, {15'h0, want}, "wait outcome");
    if (want && !hit) summarize();
  endtask
  initial begin
    {resetn_in, wr_in, rd_in, busy, req, is_load} = 6'h00;
    {addr_in, wdata_in, ptr, drp} = 48'h0;
    dly = 3'd1;
    miscompares = 0;
    n_tests = 0;
    repeat (6) @(posedge clk_in);
    resetn_in <= 1'b1;
    rd_reg(8'h00, 8'h00, "ctrl reset");
    rd_reg(8'h05, 8'h00, "unmapped");
    // table of lock, fuse and plain loads; code 00 has no enable and is refused
    foreach (rows[i]) begin
      wr_ctrl(rows[i].code, rows[i].p, 16'h0000, 1'b1, 3'd3);
      wait_out(0, 8, 1'b1);
      chk({8'h00, load_data_out}, {8'h00, rows[i].exp}, "load data");
      if (rows[i].code == 8'h00) chk(flash_addr_out, 16'h091a, "flash addr");
    end
    // buffer load into the last slot, store on the last cycle of the window
    wr_ctrl(`CODE_LOAD, 16'h003e, 16'hbeef, 1'b0, 3'd4);
    repeat (6) @(posedge clk_in);
    chk({11'h0, prog_slot_out}, 16'h001f, "slot");
    chk(prog_word_out, 16'hbeef, "word");
    // erase then write of one page, core halted for each
    wr_ctrl(`CODE_ERASE, 16'h0a7f, 16'h0000, 1'b0, 3'd1);
    wait_out(1, 4, 1'b1);
    chk({9'h0, prog_page_out}, 16'h0029, "erase page");
    chk({15'h0, core_stall_out}, 16'h0001, "erase stall");
    wait_out(3, PC + 8, 1'b1);
    rd_reg(8'h00, 8'h00, "ctrl after erase");
    chk(prog_word_out, 16'hbeef, "word kept over erase");
    wr_ctrl(`CODE_WRITE, 16'h0a40, 16'h0000, 1'b0, 3'd1);
    wait_out(2, 4, 1'b1);
    chk({9'h0, prog_page_out}, 16'h0029, "write page");
    wait_out(3, PC + 8, 1'b1);
    @(posedge clk_in);
    #1 chk(prog_word_out, 16'hffff, "buffer after write");
    // store one cycle after the window has closed
    foreach (late[i]) begin
      wr_ctrl(late[i], 16'h0a40, 16'h0000, 1'b0, 3'd5);
      wait_out(i + 1, 6, 1'b0);
      rd_reg(8'h00, 8'h00, "ctrl after timeout");
    end
    // lock read armed but load too late: plain flash byte returns
    wr_ctrl(`CODE_LOCKFUSE, 16'h0001, 16'h0000, 1'b1, 3'd4);
    wait_out(0, 8, 1'b1);
    chk({8'h00, load_data_out}, 16'h00a5, "late lock read");
    // eeprom write in progress blocks erase and arming
    busy <= 1'b1;
    wr_ctrl(`CODE_ERASE, 16'h0a7f, 16'h0000, 1'b0, 3'd1);
    wait_out(1, 6, 1'b0);
    rd_reg(8'h00, 8'h00, "ctrl while busy");
    busy <= 1'b0;
    // eeprom write starting inside an armed window blocks the store
    wr_ctrl(`CODE_ERASE, 16'h0a7f, 16'h0000, 1'b0, 3'd3);
    busy <= 1'b1;
    wait_out(1, 6, 1'b0);
    busy <= 1'b0;
    rd_reg(8'h00, 8'h00, "ctrl after blocked store");
    // word lost when an eeprom write lands during page loading
    wr_ctrl(`CODE_LOAD, 16'h0002, 16'h1357, 1'b0, 3'd1);
    repeat (3) @(posedge clk_in);
    #1 chk(prog_word_out, 16'h1357, "loaded word");
    busy <= 1'b1;
    repeat (2) @(posedge clk_in);
    busy <= 1'b0;
    repeat (2) @(posedge clk_in);
    #1 chk(prog_word_out, 16'hffff, "buffer after eeprom write");
    // reload after the loss, then the clear code empties the buffer
    wr_ctrl(`CODE_LOAD, 16'h0002, 16'h2468, 1'b0, 3'd1);
    repeat (3) @(posedge clk_in);
    #1 chk(prog_word_out, 16'h2468, "reloaded word");
    wr_ctrl(`CODE_BUFCLR, 16'h0002, 16'h0000, 1'b0, 3'd1);
    repeat (3) @(posedge clk_in);
    #1 chk(prog_word_out, 16'hffff, "buffer after clear");
    // fill slot zero so the reset below has something to clear
    wr_ctrl(`CODE_LOAD, 16'h0000, 16'h0f0f, 1'b0, 3'd1);
    repeat (3) @(posedge clk_in);
    #1 chk(prog_word_out, 16'h0f0f, "slot zero word");
    // reset during an erase drops the stall
    wr_ctrl(`CODE_ERASE, 16'h0a7f, 16'h0000, 1'b0, 3'd1);
    wait_out(1, 4, 1'b1);
    resetn_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    resetn_in <= 1'b1;
    #1 chk({15'h0, core_stall_out}, 16'h0000, "stall after reset");
    rd_reg(8'h00, 8'h00, "ctrl after reset");
    chk(prog_word_out, 16'hffff, "buffer after reset");
    summarize();
  end
endmodule // flash_self_program_sequencer_tb_top
`default_nettype wire
